// File: i2cs_pkg.sv
// Constants, state layout and register map of the two-wire bus status/data block
package i2cs_pkg;

  // ---------------------------------------------------------------
  // Register map (word index on the register port)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_ADDR = 3'h0;
  localparam logic [2:0] OFF_CTRL = 3'h2;
  localparam logic [2:0] OFF_STATUS = 3'h3;
  localparam logic [2:0] OFF_DATA = 3'h4;
  localparam logic [2:0] OFF_CTRL2 = 3'h5;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CT_EN = 7;
  localparam int CT_IE = 6;
  localparam int CT_MS = 5;
  localparam int CT_TX = 4;
  localparam int CT_TXAK = 3;
  localparam int ST_AL = 4;
  localparam int ST_EVT = 1;
  localparam int C2_GENERAL_CALL_ENABLE = 7;
  localparam int C2_ADDRESS_LENGTH_SELECT = 6;

  // ---------------------------------------------------------------
  // Reset values and address codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [2:0] ADR_HI_RST = 3'h0;
  localparam logic TCF_RST = 1'b1;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [4:0] TEN_PREFIX = 5'h1E;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_INT = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] SCL_HALF_CYC = SCL_HALF_INT[9:0];

  // ---------------------------------------------------------------
  // Master line sequencer and block state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_HOLD = 3'b010,
    M_HIGH = 3'b011,
    M_STOP1 = 3'b100,
    M_STOP2 = 3'b101
  } i2cs_mst_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [7:0] own_addr;
    logic en;
    logic ie;
    logic msel;
    logic msel_d;
    logic tx;
    logic txak;
    logic general_call_enable;
    logic address_length_select;
    logic [2:0] adr_hi;
    logic byte_done_flag;
    logic own_address_hit_flag;
    logic busy;
    logic al;
    logic slave_direction_flag;
    logic bus_event_flag;
    logic ack_received_level;
    logic [7:0] data_tx;
    logic [7:0] data_rx;
    logic [3:0] bitcnt;
    logic got_rise;
    logic xfer;
    logic addr_phase;
    logic ack_addr;
    logic hit_pend;
    logic ten_first;
    logic ten_done;
    logic slave_act;
    logic scl_hold;
    i2cs_mst_t mst;
    logic [9:0] cnt;
    logic [7:0] rdata;
    logic irq;
    logic sda_oe;
    logic scl_oe;
    logic line_lvl;
  } i2cs_state_t;

endpackage

// File: i2cs_core.sv
// Two-wire bus controller: status, data and second control register with byte engine
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module i2cs_core
  import i2cs_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Interrupt request
  output logic irq_o,
  // Bus lines, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  i2cs_state_t s_r;
  i2cs_state_t s_nxt;

  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;
    logic m7;
    logic mgc;
    logic m10a;
    logic m2nd;
    logic tx_dir;
    logic drv;
    logic mine;
    scl_rise = s_r.scl_s & ~s_r.scl_p;
    scl_fall = ~s_r.scl_s & s_r.scl_p;
    sda_rise = s_r.sda_s & ~s_r.sda_p;
    sda_fall = ~s_r.sda_s & s_r.sda_p;
    m7 = ~s_r.address_length_select && (s_r.data_rx[7:1] == s_r.own_addr[7:1]);
    mgc = s_r.general_call_enable && (s_r.data_rx == GC_ADDR);
    m10a = s_r.address_length_select && (s_r.data_rx[7:3] == TEN_PREFIX)
      && (s_r.data_rx[2:1] == s_r.adr_hi[1:0]);
    m2nd = s_r.data_rx == s_r.own_addr;
    tx_dir = s_r.addr_phase ? 1'b0 : s_r.tx;
    mine = s_r.msel | s_r.slave_act;
    drv = 1'b0;
    s_nxt = s_r;

    s_nxt.scl_m = scl_i;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_p = s_r.scl_s;
    s_nxt.sda_m = sda_i;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_p = s_r.sda_s;
    s_nxt.msel_d = s_r.msel;
    s_nxt.rdata = 8'h00;

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    if (wr_i)
    begin
      case (addr_i)
        OFF_ADDR: s_nxt.own_addr = wdata_i;
        OFF_CTRL:
        begin
          s_nxt.en = wdata_i[CT_EN];
          s_nxt.ie = wdata_i[CT_IE];
          s_nxt.msel = wdata_i[CT_MS];
          s_nxt.tx = wdata_i[CT_TX];
          s_nxt.txak = wdata_i[CT_TXAK];
          s_nxt.own_address_hit_flag = 1'b0;
        end
        OFF_STATUS:
        begin
          if (wdata_i[ST_EVT])
            s_nxt.bus_event_flag = 1'b0;
          if (wdata_i[ST_AL])
            s_nxt.al = 1'b0;
        end
        OFF_DATA:
        begin
          s_nxt.data_tx = wdata_i;
          if (s_r.tx && mine && !s_r.xfer)
          begin
            s_nxt.xfer = 1'b1;
            s_nxt.bitcnt = 4'h0;
            s_nxt.got_rise = 1'b0;
            s_nxt.byte_done_flag = 1'b0;
            s_nxt.scl_hold = 1'b0;
          end
        end
        OFF_CTRL2:
        begin
          s_nxt.general_call_enable = wdata_i[C2_GENERAL_CALL_ENABLE];
          s_nxt.address_length_select = wdata_i[C2_ADDRESS_LENGTH_SELECT];
          s_nxt.adr_hi = wdata_i[2:0];
        end
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // Register reads, answer in the next cycle
    // ---------------------------------------------------------------
    if (rd_i)
    begin
      case (addr_i)
        OFF_ADDR: s_nxt.rdata = s_r.own_addr;
        OFF_CTRL: s_nxt.rdata = {s_r.en, s_r.ie, s_r.msel, s_r.tx, s_r.txak, 3'h0};
        OFF_STATUS: s_nxt.rdata = {s_r.byte_done_flag, s_r.own_address_hit_flag, s_r.busy, s_r.al, 1'b0,
          s_r.slave_direction_flag, s_r.bus_event_flag, s_r.ack_received_level};
        OFF_DATA:
        begin
          s_nxt.rdata = s_r.data_rx;
          if (!s_r.tx && mine && !s_r.xfer)
          begin
            s_nxt.xfer = 1'b1;
            s_nxt.bitcnt = 4'h0;
            s_nxt.got_rise = 1'b0;
            s_nxt.byte_done_flag = 1'b0;
            s_nxt.scl_hold = 1'b0;
          end
        end
        OFF_CTRL2: s_nxt.rdata = {s_r.general_call_enable, s_r.address_length_select, 3'h0, s_r.adr_hi};
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // ---------------------------------------------------------------
    // Bus conditions; hardware sets come last so they win over clears
    // ---------------------------------------------------------------
    if (s_r.scl_s && s_r.scl_p && sda_fall)
    begin
      s_nxt.busy = 1'b1;
      s_nxt.bitcnt = 4'h0;
      s_nxt.got_rise = 1'b0;
      s_nxt.ten_first = 1'b0;
      s_nxt.slave_act = 1'b0;
      s_nxt.scl_hold = 1'b0;
      if (!s_r.msel && s_r.en)
      begin
        s_nxt.addr_phase = 1'b1;
        s_nxt.xfer = 1'b1;
        s_nxt.byte_done_flag = 1'b0;
      end
    end
    else if (s_r.scl_s && s_r.scl_p && sda_rise)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.xfer = 1'b0;
      s_nxt.addr_phase = 1'b0;
      s_nxt.slave_act = 1'b0;
      s_nxt.ten_first = 1'b0;
      s_nxt.ten_done = 1'b0;
      s_nxt.scl_hold = 1'b0;
    end
    else if (s_r.xfer && scl_rise)
    begin
      s_nxt.got_rise = 1'b1;
      if (s_r.bitcnt == ACK_BIT)
        s_nxt.ack_received_level = s_r.sda_s;
      else
      begin
        s_nxt.data_rx = {s_r.data_rx[6:0], s_r.sda_s};
        // Lost arbitration: we released SDA but another party holds it low
        if (s_r.msel && tx_dir && s_r.data_tx[3'h7 - s_r.bitcnt[2:0]] && !s_r.sda_s)
        begin
          s_nxt.al = 1'b1;
          s_nxt.bus_event_flag = 1'b1;
          s_nxt.msel = 1'b0;
          s_nxt.xfer = 1'b0;
          s_nxt.mst = M_IDLE;
        end
      end
    end
    else if (s_r.xfer && scl_fall && s_r.got_rise)
    begin
      s_nxt.got_rise = 1'b0;
      if (s_r.bitcnt == LAST_DATA_BIT && s_r.addr_phase)
      begin
        s_nxt.ack_addr = s_r.ten_first ? m2nd : (m7 | mgc | m10a);
        s_nxt.hit_pend = s_r.ten_first ? m2nd
          : (m7 | mgc | (m10a & s_r.ten_done & s_r.data_rx[0]));
        s_nxt.bitcnt = ACK_BIT;
      end
      else if (s_r.bitcnt == ACK_BIT)
      begin
        s_nxt.bitcnt = 4'h0;
        s_nxt.ack_addr = 1'b0;
        s_nxt.hit_pend = 1'b0;
        if (!s_r.addr_phase)
        begin
          s_nxt.xfer = 1'b0;
          s_nxt.byte_done_flag = 1'b1;
          s_nxt.bus_event_flag = 1'b1;
          s_nxt.scl_hold = s_r.slave_act;
        end
        else if (s_r.hit_pend)
        begin
          s_nxt.own_address_hit_flag = 1'b1;
          s_nxt.bus_event_flag = 1'b1;
          s_nxt.byte_done_flag = 1'b1;
          s_nxt.slave_direction_flag = s_r.ten_first ? 1'b0 : s_r.data_rx[0];
          s_nxt.slave_act = 1'b1;
          s_nxt.ten_done = s_r.ten_done | s_r.ten_first | s_r.address_length_select;
          s_nxt.ten_first = 1'b0;
          s_nxt.addr_phase = 1'b0;
          s_nxt.xfer = 1'b0;
          s_nxt.scl_hold = 1'b1;
        end
        else if (s_r.ack_addr && !s_r.ten_first)
          s_nxt.ten_first = 1'b1;
        else
        begin
          s_nxt.addr_phase = 1'b0;
          s_nxt.xfer = 1'b0;
        end
      end
      else
        s_nxt.bitcnt = s_r.bitcnt + 4'h1;
    end

    // ---------------------------------------------------------------
    // Master line sequencer; bit timing from a fixed half period
    // ---------------------------------------------------------------
    unique case (s_r.mst)
      M_IDLE:
      begin
        s_nxt.cnt = 10'h000;
        if (s_r.msel && !s_r.msel_d)
        begin
          if (s_r.busy)
          begin
            s_nxt.al = 1'b1;
            s_nxt.bus_event_flag = 1'b1;
            s_nxt.msel = 1'b0;
          end
          else
            s_nxt.mst = M_START;
        end
      end
      M_START, M_STOP1, M_STOP2, M_HIGH:
      begin
        s_nxt.cnt = s_r.cnt + 10'h001;
        if (s_r.cnt == SCL_HALF_CYC)
        begin
          s_nxt.cnt = 10'h000;
          s_nxt.mst = (s_r.mst == M_STOP1) ? M_STOP2
            : (s_r.mst == M_STOP2) ? M_IDLE : M_HOLD;
        end
      end
      M_HOLD:
      begin
        // The wait lets a finished byte drop xfer before the next pulse
        if (s_r.cnt != SCL_HALF_CYC)
          s_nxt.cnt = s_r.cnt + 10'h001;
        else if (s_r.xfer)
        begin
          s_nxt.cnt = 10'h000;
          s_nxt.mst = M_HIGH;
        end
        else if (!s_r.msel)
        begin
          s_nxt.cnt = 10'h000;
          s_nxt.mst = M_STOP1;
        end
      end
    endcase

    // ---------------------------------------------------------------
    // Line drive and interrupt
    // ---------------------------------------------------------------
    if (s_r.bitcnt < ACK_BIT)
      drv = tx_dir & ~s_r.data_tx[3'h7 - s_r.bitcnt[2:0]];
    else
      drv = s_r.addr_phase ? s_r.ack_addr : (~tx_dir & ~s_r.txak);
    s_nxt.sda_oe = s_r.en & ((s_r.xfer & drv) | (s_r.mst == M_START)
      | (s_r.mst == M_STOP1) | (s_r.mst == M_STOP2));
    // Slave holds SCL low until software services the byte
    s_nxt.scl_oe = s_r.en & (s_r.scl_hold | (s_r.mst == M_HOLD) | (s_r.mst == M_STOP1));
    s_nxt.irq = s_r.bus_event_flag & s_r.ie;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_r <= '0;
      s_r.own_addr <= ADDR_RST;
      s_r.adr_hi <= ADR_HI_RST;
      s_r.byte_done_flag <= TCF_RST;
      s_r.scl_m <= 1'b1;
      s_r.scl_s <= 1'b1;
      s_r.scl_p <= 1'b1;
      s_r.sda_m <= 1'b1;
      s_r.sda_s <= 1'b1;
      s_r.sda_p <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign rdata_o = s_r.rdata;
  assign irq_o = s_r.irq;
  assign scl_o = s_r.line_lvl;
  assign scl_oe_o = s_r.scl_oe;
  assign sda_o = s_r.line_lvl;
  assign sda_oe_o = s_r.sda_oe;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  a_status_rsv_zero: assert property (
    rd_i && addr_i == OFF_STATUS |=> !rdata_o[3])
    else $error("status reserved bit read as one");
  a_ctrl2_rsv_zero: assert property (
    rd_i && addr_i == OFF_CTRL2 |=> rdata_o[5:3] == 3'h0)
    else $error("control2 reserved bits read nonzero");
  a_irq_follows_event: assert property (
    s_r.bus_event_flag && s_r.ie |=> irq_o ##1 (irq_o || !$past(s_r.bus_event_flag && s_r.ie)))
    else $error("interrupt not raised for enabled event");
  a_event_zero_write: assert property (
    wr_i && addr_i == OFF_STATUS && !wdata_i[ST_EVT] && s_r.bus_event_flag |=> s_r.bus_event_flag)
    else $error("zero write cleared event flag");
  a_done_sets_event: assert property (
    $rose(s_r.byte_done_flag) |-> s_r.bus_event_flag)
    else $error("byte done without event flag");
  a_ack_capture: assert property (
    s_r.xfer && s_r.scl_s && !s_r.scl_p && s_r.bitcnt == ACK_BIT
      |=> s_r.ack_received_level == $past(s_r.sda_s))
    else $error("ack level not captured");
  a_tx_write_start: assert property (
    wr_i && addr_i == OFF_DATA && s_r.tx && s_r.msel && !s_r.xfer
      && !(s_r.scl_s && s_r.scl_p && (s_r.sda_s != s_r.sda_p))
      |=> s_r.xfer && !s_r.byte_done_flag && s_r.bitcnt == 4'h0)
    else $error("data write did not start transmit");
  a_wrong_dir_read: assert property (
    rd_i && addr_i == OFF_DATA && s_r.tx && !s_r.xfer && !wr_i
      && !(s_r.scl_s && s_r.scl_p && !s_r.sda_s && s_r.sda_p) |=> !s_r.xfer)
    else $error("read started transfer in transmit mode");
  a_gc_ignored: assert property (
    $rose(s_r.own_address_hit_flag) && !s_r.address_length_select |-> s_r.general_call_enable || s_r.data_rx != GC_ADDR)
    else $error("general call accepted while disabled");
  a_srw_from_caller: assert property (
    $rose(s_r.own_address_hit_flag) && !s_r.address_length_select |-> s_r.slave_direction_flag == s_r.data_rx[0])
    else $error("slave direction differs from caller bit");
  a_done_low_xfer: assert property (
    s_r.xfer |-> !s_r.byte_done_flag)
    else $error("byte done flag set during transfer");

endmodule // i2cs_core

// File: i2cs_bus_mst.sv
// Behavioural two-wire bus master that calls the block as a slave
`timescale 1ns/1ps

module i2cs_bus_mst
(
  // Wired line levels
  input wire logic scl_i,
  input wire logic sda_i,
  // Open-drain pulls, high pulls the line low
  output logic scl_low_o,
  output logic sda_low_o
);
  // 90 ns link clock period: 50 ns low, 40 ns high
  localparam int HALF = 40;

  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  // ---------------------------------------------------------------
  // Line primitives
  // ---------------------------------------------------------------
  // Slave may stretch SCL; bounded wait, the watchdog covers a hang
  task automatic release_scl();
    int k;
    scl_low_o = 1'b0;
    for (k = 0; k < 20000 && scl_i !== 1'b1; k++)
    begin
      #10;
    end
  endtask

  // Data changes only while SCL is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    #10;
    sda_low_o = ~b;
    #HALF;
    release_scl();
    #HALF;
    r = sda_i;
    scl_low_o = 1'b1;
  endtask

  task automatic start();
    #3;
    sda_low_o = 1'b1;
    #HALF;
    scl_low_o = 1'b1;
  endtask

  task automatic rstart();
    #10;
    sda_low_o = 1'b0;
    #HALF;
    release_scl();
    #HALF;
    start();
  endtask

  task automatic stop();
    #10;
    sda_low_o = 1'b1;
    #HALF;
    release_scl();
    #HALF;
    sda_low_o = 1'b0;
    #HALF;
  endtask

  // Most significant bit first, ninth clock carries the acknowledge
  task automatic xfer(input logic [7:0] tx, input logic ack_out,
                      output logic [7:0] rx, output logic ack_in);
    int i;
    logic b;
    for (i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], b);
      rx[i] = b;
    end
    bit_io(ack_out, ack_in);
  endtask
endmodule // i2cs_bus_mst

// File: i2c_status_data_addr_regs_tb_top.sv
// Self-checking bench: register port and slave traffic of the status/data block
`timescale 1ns/1ps

module i2c_status_data_addr_regs_tb_top
  import i2cs_pkg::*;
;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o, scl_low, sda_low;
  int errors = 0;
  int samples_checked = 0;
  int seed = 32'hA27C;
  // Wired-AND lines with pull-ups
  wire scl_w = ~((scl_oe_o & ~scl_o) | scl_low);
  wire sda_w = ~((sda_oe_o & ~sda_o) | sda_low);

  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end

  i2cs_core u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o));

  i2cs_bus_mst u_mst (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(scl_low),
    .sda_low_o(sda_low));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Status after a matched address: done, busy, event, acked
  function automatic logic [7:0] st_exp(input logic hit, input logic dir);
    return {1'b1, hit, 1'b1, 2'b00, dir, 2'b10};
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs about 8 us of bus time
  initial
  begin
    #400000;
    errors++;
    $display("watchdog expired");
    summarize();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [6:0] oa;
    logic [7:0] d, rx, r;
    logic [2:0] hi;
    logic ak;
    int i;
    oa = 7'h08 + 7'($random(seed) & 32'h3F);
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    cyc(3);
    rd_chk(OFF_STATUS, 8'hFF, 8'h80);
    rd_chk(OFF_CTRL2, 8'hFF, 8'h00);
    rd_chk(3'h1, 8'hFF, 8'h00);
    wr(OFF_STATUS, 8'hFF);
    rd_chk(OFF_STATUS, 8'hFF, 8'h80);
    for (i = 0; i < 4; i++)
    begin
      r = 8'($random(seed));
      wr(OFF_CTRL2, r);
      rd_chk(OFF_CTRL2, 8'hFF, r & 8'hC7);
    end
    wr(OFF_CTRL2, 8'h00);
    $display("test registers done");

    wr(OFF_ADDR, {oa, 1'b0});
    wr(OFF_CTRL, 8'hC0);
    cyc(4);
    u_mst.start();
    u_mst.xfer({oa, 1'b0}, 1'b1, rx, ak);
    chk({7'h0, ak}, 8'h00);
    cyc(8);
    rd_chk(OFF_STATUS, 8'hFF, st_exp(1'b1, 1'b0));
    chk({irq_o, scl_oe_o, 6'h0}, 8'hC0);
    wr(OFF_STATUS, 8'hFD);
    rd_chk(OFF_STATUS, 8'hFF, st_exp(1'b1, 1'b0));
    wr(OFF_STATUS, 8'h02);
    cyc(2);
    rd_chk(OFF_STATUS, 8'h02, 8'h00);
    chk({7'h0, irq_o}, 8'h00);
    wr(OFF_CTRL, 8'hD0);
    rd(OFF_DATA, r);
    cyc(6);
    chk({7'h0, scl_oe_o}, 8'h01);
    wr(OFF_CTRL, 8'hC0);
    rd(OFF_DATA, r);
    cyc(6);
    chk({7'h0, scl_oe_o}, 8'h00);
    d = 8'($random(seed));
    u_mst.xfer(d, 1'b1, rx, ak);
    chk({7'h0, ak}, 8'h00);
    cyc(8);
    rd_chk(OFF_STATUS, 8'h83, 8'h82);
    rd_chk(OFF_DATA, 8'hFF, d);
    wr(OFF_STATUS, 8'h02);
    $display("test slave receive done");

    u_mst.rstart();
    u_mst.xfer({oa, 1'b1}, 1'b1, rx, ak);
    chk({7'h0, ak}, 8'h00);
    cyc(8);
    rd_chk(OFF_STATUS, 8'hFF, st_exp(1'b1, 1'b1));
    wr(OFF_STATUS, 8'h02);
    wr(OFF_CTRL, 8'hD0);
    d = 8'($random(seed));
    wr(OFF_DATA, d);
    u_mst.xfer(8'hFF, 1'b1, rx, ak);
    chk(rx, d);
    cyc(8);
    rd_chk(OFF_STATUS, 8'h83, 8'h83);
    wr(OFF_CTRL, 8'hC0);
    rd(OFF_DATA, r);
    u_mst.stop();
    wr(OFF_STATUS, 8'h02);
    $display("test slave transmit done");

    cyc(4);
    u_mst.start();
    u_mst.xfer(GC_ADDR, 1'b1, rx, ak);
    chk({7'h0, ak}, 8'h01);
    u_mst.stop();
    rd_chk(OFF_STATUS, 8'h40, 8'h00);
    wr(OFF_CTRL2, 8'h80);
    u_mst.start();
    u_mst.xfer(GC_ADDR, 1'b1, rx, ak);
    chk({7'h0, ak}, 8'h00);
    cyc(8);
    rd_chk(OFF_STATUS, 8'h46, 8'h42);
    wr(OFF_STATUS, 8'h02);
    rd(OFF_DATA, r);
    u_mst.stop();
    $display("test general call done");

    hi = 3'($random(seed));
    d = 8'($random(seed));
    wr(OFF_CTRL2, {5'h08, hi});
    wr(OFF_ADDR, d);
    wr(OFF_CTRL, 8'hC0);
    u_mst.start();
    u_mst.xfer({TEN_PREFIX, ~hi[1], hi[0], 1'b0}, 1'b1, rx, ak);
    chk({7'h0, ak}, 8'h01);
    u_mst.stop();
    u_mst.start();
    u_mst.xfer({TEN_PREFIX, hi[1:0], 1'b0}, 1'b1, rx, ak);
    u_mst.xfer(d, 1'b1, rx, ak);
    chk({7'h0, ak}, 8'h00);
    cyc(8);
    rd_chk(OFF_STATUS, 8'h46, 8'h42);
    rd(OFF_DATA, r);
    u_mst.stop();
    $display("test ten-bit address done");
    summarize();
  end
endmodule // i2c_status_data_addr_regs_tb_top
